// ===== core/ems_encoder_master_sequencer.sv
/*
  Master sequencer for a half-duplex serial encoder link: bit clock for a slave
  shift port, line drive enable, start-bit wait and reply clocking, APB registers.
  Assumes the shift port and transceiver sit outside; the data pin is asynchronous.
*/
//
// Contract
// R01 - start acts only on a rising edge of the software start bit
// R02 - encoder edge input is the same receive line the shift port samples
// R03 - output enable mask resets to 0x3C, enabling outputs two to five
// R04 - shift port runs as clock slave, its clock only from this sequencer
// R05 - sequencer reset clears counters and returns state machines to idle
// R06 - software programs shift port level and word length per command
// R07 - line direction control leaves on output crossbar six
// R08 - mode codes 0,1,2,3,6,7,8,C,D supported, each with own lengths
// R09 - command setup loads data and causes no line activity
// R10 - every transaction begins with a command setup
// R11 - start is a separate later action performing the prepared exchange
// R12 - software configures everything after system reset before any transaction
// R13 - bit rate programmable through clock counter match values
// R14 - line drive enable high only while command bits are sent
// R15 - counter with two match values makes the shift clock, nominally 2.5 MBPS
// R16 - after sending, clock stops until the encoder start bit arrives
// R17 - reply phase gives reply length plus padding clocks, then idles
// R18 - done flag raised on return to idle; starts ignored while busy
`timescale 1ns/1ps
module ems_encoder_master_sequencer #(
  parameter int unsigned FIFO_WIDTH = 32,
  parameter int unsigned FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link pins
  input wire logic encoder_edge_input,
  output logic shift_clk_out,
  output logic shift_clk_oe,
  output logic output_crossbar_six
);

  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
  localparam int unsigned BW = $clog2(FIFO_WIDTH + 1);

  if (FIFO_WIDTH < 1 || FIFO_WIDTH > 32) begin : g_bad_width
    $error("fifo width must be 1 to 32");
  end
  if (CW > 4) begin : g_bad_level
    $error("fifo depth must be below 16 to fit the status field");
  end

  // registers
  logic [7:0] ctrl_reg;
  logic seq_reset_reg;
  logic start_prev_reg;
  logic [3:0] mode_reg;
  logic [7:0] tx_len_reg;
  logic [7:0] rx_len_reg;
  logic [7:0] pad_len_reg;
  logic [15:0] match1_reg;
  logic [15:0] match2_reg;
  logic [7:0] outmask_reg;
  logic done_reg;
  logic err_reg;
  ems_pkg::ems_state_t state_reg;
  logic [15:0] div_cnt_reg;
  logic [8:0] bit_cnt_reg;
  logic [2:0] enc_sync_reg;
  logic enc_level_reg;
  logic [FIFO_WIDTH-1:0] rx_shift_reg;
  logic [BW-1:0] rx_bits_reg;
  logic push_pending_reg;
  logic [FIFO_WIDTH-1:0] push_word_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic shift_clk_reg;
  logic shift_clk_oe_reg;
  logic drive_reg;

  // combinational terms
  logic access;
  logic wr;
  logic [31:0] ctrl_word;
  logic [31:0] cmd_word;
  logic [31:0] div_word;
  logic seq_clear;
  logic start_rise;
  logic busy;
  logic cfg_ok;
  logic go;
  logic refuse;
  logic stall;
  logic run;
  logic div_wrap;
  logic last_tx;
  logic last_rx;
  logic rx_end;
  logic sample;
  logic enc_fall;
  logic [8:0] rx_total;
  logic [FIFO_WIDTH-1:0] shifted;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [CW-1:0] fifo_level;
  logic [31:0] rdata;
  logic hit;

  // apb decode: one wait state, write and pop at the completing edge
  assign access = psel & penable & pready_reg;
  assign wr = access & pwrite;
  assign ctrl_word = ems_pkg::ems_merge({24'h000000, ctrl_reg}, pwdata, pstrb);
  assign cmd_word = ems_pkg::ems_merge({28'h0000000, mode_reg}, pwdata, pstrb);
  assign div_word = ems_pkg::ems_merge({match2_reg, match1_reg}, pwdata, pstrb);
  assign fifo_pop = access & !pwrite & (paddr == ems_pkg::OFS_RXDATA) & fifo_out_valid;

  // sequencer control terms
  assign seq_clear = seq_reset_reg | !ctrl_reg[ems_pkg::CTRL_ENABLE_BIT]; // [R05]
  assign start_rise = ctrl_reg[ems_pkg::CTRL_START_BIT] & !start_prev_reg; // [R01]
  assign busy = (state_reg != ems_pkg::ST_IDLE) | push_pending_reg;
  assign rx_total = {1'b0, rx_len_reg} + {1'b0, pad_len_reg}; // [R17]
  assign cfg_ok = ems_pkg::ems_mode_supported(mode_reg) && (tx_len_reg != 8'h00) &&
                  (rx_total != 9'h000); // [R08]
  assign go = start_rise & !busy & !seq_clear & cfg_ok; // [R18]
  assign refuse = start_rise & !busy & !seq_clear & !cfg_ok;
  assign stall = push_pending_reg & !fifo_in_ready;
  assign run = ((state_reg == ems_pkg::ST_TX) | (state_reg == ems_pkg::ST_RX)) & !stall;
  assign div_wrap = run & (div_cnt_reg == match2_reg); // [R15]
  assign last_tx = (bit_cnt_reg + 9'h001) == {1'b0, tx_len_reg};
  assign last_rx = (bit_cnt_reg + 9'h001) == rx_total;
  assign rx_end = div_wrap & (state_reg == ems_pkg::ST_RX) & last_rx;
  assign sample = run & (state_reg == ems_pkg::ST_RX) & (div_cnt_reg == match1_reg);
  assign shifted = (FIFO_WIDTH > 1) ? {enc_level_reg, rx_shift_reg[FIFO_WIDTH-1:1]} :
                   FIFO_WIDTH'(enc_level_reg);
  // falling edge once second and third stages agree
  assign enc_fall = (enc_sync_reg[1] == enc_sync_reg[2]) & !enc_sync_reg[1] & enc_level_reg;

  // control register with self-clearing sequencer reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= ems_pkg::CTRL_RST;
      seq_reset_reg <= 1'b0;
    end else begin
      if (wr && paddr == ems_pkg::OFS_CTRL) begin
        ctrl_reg <= ctrl_word[7:0] & ems_pkg::CTRL_KEEP_MASK;
      end
      seq_reset_reg <= wr && (paddr == ems_pkg::OFS_CTRL) &&
                       ctrl_word[ems_pkg::CTRL_SEQ_RESET_BIT]; // [R05]
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= ctrl_reg[ems_pkg::CTRL_START_BIT]; // [R01]
    end
  end

  // command, lengths, clock matches and output mask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= ems_pkg::MODE_RST;
      tx_len_reg <= ems_pkg::TX_LEN_RST;
      rx_len_reg <= ems_pkg::RX_LEN_RST;
      pad_len_reg <= ems_pkg::PAD_LEN_RST;
      match1_reg <= ems_pkg::MATCH1_RST;
      match2_reg <= ems_pkg::MATCH2_RST;
      outmask_reg <= ems_pkg::OUTMASK_RST; // [R03]
    end else if (wr) begin
      case (paddr)
        ems_pkg::OFS_CMD: begin
          mode_reg <= cmd_word[3:0];
        end
        ems_pkg::OFS_LEN: begin
          tx_len_reg <= pstrb[0] ? pwdata[ems_pkg::LEN_TX_POS +: 8] : tx_len_reg;
          rx_len_reg <= pstrb[1] ? pwdata[ems_pkg::LEN_RX_POS +: 8] : rx_len_reg;
          pad_len_reg <= pstrb[2] ? pwdata[ems_pkg::LEN_PAD_POS +: 8] : pad_len_reg;
        end
        ems_pkg::OFS_CLKDIV: begin
          match1_reg <= div_word[ems_pkg::CLKDIV_M1_POS +: 16]; // [R13]
          match2_reg <= div_word[ems_pkg::CLKDIV_M2_POS +: 16]; // [R13]
        end
        ems_pkg::OFS_OUTMASK: begin
          outmask_reg <= pstrb[0] ? pwdata[7:0] : outmask_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (rx_end) begin
        done_reg <= 1'b1; // [R18]
      end else if (wr && paddr == ems_pkg::OFS_STATUS && pstrb[0] &&
                   pwdata[ems_pkg::ST_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (refuse) begin
        err_reg <= 1'b1;
      end else if (wr && paddr == ems_pkg::OFS_STATUS && pstrb[0] &&
                   pwdata[ems_pkg::ST_ERR_BIT]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // encoder data pin synchroniser and filtered level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_sync_reg <= 3'h7;
      enc_level_reg <= 1'b1;
    end else begin
      enc_sync_reg <= {enc_sync_reg[1:0], encoder_edge_input}; // [R02]
      if (enc_sync_reg[1] == enc_sync_reg[2]) begin
        enc_level_reg <= enc_sync_reg[1];
      end
    end
  end

  // main state machine
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ems_pkg::ST_IDLE;
    end else if (seq_clear) begin
      state_reg <= ems_pkg::ST_IDLE; // [R05]
    end else begin
      unique case (state_reg)
        ems_pkg::ST_IDLE: if (go) state_reg <= ems_pkg::ST_TX; // [R01]
        ems_pkg::ST_TX: if (div_wrap && last_tx) state_reg <= ems_pkg::ST_WAIT;
        ems_pkg::ST_WAIT: if (enc_fall) state_reg <= ems_pkg::ST_RX; // [R16]
        ems_pkg::ST_RX: if (rx_end) state_reg <= ems_pkg::ST_IDLE; // [R17]
      endcase
    end
  end

  // bit clock divider and bit counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 16'h0000;
      bit_cnt_reg <= 9'h000;
    end else if (seq_clear || !run) begin
      if (seq_clear || state_reg == ems_pkg::ST_IDLE || state_reg == ems_pkg::ST_WAIT) begin
        div_cnt_reg <= 16'h0000; // [R16]
        bit_cnt_reg <= 9'h000; // [R05]
      end
    end else if (div_wrap) begin
      div_cnt_reg <= 16'h0000; // [R15]
      if ((state_reg == ems_pkg::ST_TX && last_tx) || last_rx) begin
        bit_cnt_reg <= 9'h000;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 9'h001;
      end
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // reply capture, lsb first, words handed to the fifo
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_shift_reg <= '0;
      rx_bits_reg <= '0;
      push_pending_reg <= 1'b0;
      push_word_reg <= '0;
    end else if (seq_reset_reg) begin
      rx_shift_reg <= '0;
      rx_bits_reg <= '0;
      push_pending_reg <= 1'b0;
    end else begin
      if (sample && rx_bits_reg == BW'(FIFO_WIDTH - 1)) begin
        push_word_reg <= shifted;
        rx_shift_reg <= '0;
        rx_bits_reg <= '0;
        push_pending_reg <= 1'b1;
      end else if (sample) begin
        rx_shift_reg <= shifted;
        rx_bits_reg <= rx_bits_reg + BW'(1);
      end else if (rx_end && rx_bits_reg != '0) begin
        push_word_reg <= rx_shift_reg;
        rx_shift_reg <= '0;
        rx_bits_reg <= '0;
        push_pending_reg <= 1'b1;
      end else if (push_pending_reg && fifo_in_ready) begin
        push_pending_reg <= 1'b0;
      end
    end
  end

  ems_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flush(seq_reset_reg),
    .in_valid(push_pending_reg),
    .in_ready(fifo_in_ready),
    .in_data(push_word_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // pin outputs gated by the output enable mask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_clk_reg <= 1'b0;
      shift_clk_oe_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      shift_clk_reg <= run & (div_cnt_reg < match1_reg) &
                       outmask_reg[ems_pkg::OUT_SHIFT_CLK_BIT]; // [R04]
      shift_clk_oe_reg <= ctrl_reg[ems_pkg::CTRL_CLK_OE_BIT] &
                          outmask_reg[ems_pkg::OUT_CLK_OE_BIT]; // [R03]
      drive_reg <= !seq_clear & (state_reg == ems_pkg::ST_TX) &
                   outmask_reg[ems_pkg::OUT_DRIVE_BIT]; // [R14]
    end
  end

  // read mux
  always_comb begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      ems_pkg::OFS_CTRL: rdata[7:0] = ctrl_reg;
      ems_pkg::OFS_CMD: rdata[3:0] = mode_reg;
      ems_pkg::OFS_LEN: rdata[23:0] = {pad_len_reg, rx_len_reg, tx_len_reg};
      ems_pkg::OFS_CLKDIV: rdata = {match2_reg, match1_reg};
      ems_pkg::OFS_OUTMASK: rdata[7:0] = outmask_reg;
      ems_pkg::OFS_STATUS: begin
        rdata[ems_pkg::ST_BUSY_BIT] = busy;
        rdata[ems_pkg::ST_STATE_POS +: 2] = state_reg;
        rdata[ems_pkg::ST_DONE_BIT] = done_reg;
        rdata[ems_pkg::ST_ERR_BIT] = err_reg;
        rdata[ems_pkg::ST_LEVEL_POS +: CW] = fifo_level;
      end
      ems_pkg::OFS_RXDATA: begin
        if (fifo_out_valid) begin
          rdata[FIFO_WIDTH-1:0] = fifo_out_data;
        end
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel & penable & !pready_reg;
      pslverr_reg <= psel & penable & !pready_reg & !hit;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h00000000 : rdata;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign shift_clk_out = shift_clk_reg;
  assign shift_clk_oe = shift_clk_oe_reg;
  assign output_crossbar_six = drive_reg; // [R07]

endmodule : ems_encoder_master_sequencer

// ===== core/ems_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ems_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned LW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("ems_fifo depth must be at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [LW-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready = (level_reg != LW'(DEPTH));
  assign out_valid = (level_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign level = level_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        level_reg <= level_reg + LW'(1);
      end else if (pop && !push) begin
        level_reg <= level_reg - LW'(1);
      end
    end
  end

endmodule : ems_fifo

// ===== core/ems_pkg.sv
/*
  Constants, types and helpers shared by the encoder master sequencer and its testbench.
  Assumes a 200 MHz core clock and an APB register bus with 32-bit data.
*/
package ems_pkg;

  // timing
  localparam int unsigned CORE_CLK_HZ = 200_000_000;
  localparam int unsigned LINK_BIT_RATE_HZ = 2_500_000;
  localparam int unsigned BIT_CYCLES = CORE_CLK_HZ / LINK_BIT_RATE_HZ;
  localparam logic [15:0] MATCH1_RST = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] MATCH2_RST = 16'(BIT_CYCLES - 1);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_LEN = 8'h08;
  localparam logic [7:0] OFS_CLKDIV = 8'h0C;
  localparam logic [7:0] OFS_OUTMASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RXDATA = 8'h18;

  // control bits
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ENABLE_BIT = 1;
  localparam int unsigned CTRL_SEQ_RESET_BIT = 2;
  localparam int unsigned CTRL_CLK_OE_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'h0B;

  // length fields
  localparam int unsigned LEN_TX_POS = 0;
  localparam int unsigned LEN_RX_POS = 8;
  localparam int unsigned LEN_PAD_POS = 16;
  localparam logic [7:0] TX_LEN_RST = 8'h00;
  localparam logic [7:0] RX_LEN_RST = 8'h00;
  localparam logic [7:0] PAD_LEN_RST = 8'h00;

  // clock divider fields
  localparam int unsigned CLKDIV_M1_POS = 0;
  localparam int unsigned CLKDIV_M2_POS = 16;

  // output enable mask
  localparam logic [7:0] OUTMASK_RST = 8'h3C;
  localparam int unsigned OUT_SHIFT_CLK_BIT = 2;
  localparam int unsigned OUT_CLK_OE_BIT = 3;
  localparam int unsigned OUT_DRIVE_BIT = 4;

  // status fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_STATE_POS = 1;
  localparam int unsigned ST_DONE_BIT = 3;
  localparam int unsigned ST_ERR_BIT = 4;
  localparam int unsigned ST_LEVEL_POS = 8;

  localparam logic [3:0] MODE_RST = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX = 2'b01,
    ST_WAIT = 2'b11,
    ST_RX = 2'b10
  } ems_state_t;

  // mode command codes the master supports
  function automatic logic ems_mode_supported(input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : ems_mode_supported

  // apply apb byte strobes to a register image
  function automatic logic [31:0] ems_merge(input logic [31:0] old_word,
                                            input logic [31:0] wdata,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction : ems_merge

endpackage : ems_pkg

// ===== tb/ems_enc_model.sv
/*
  Encoder stand-in on the half-duplex data line.
  Assumes the line idles high through fail-safe bias when nobody drives it.
*/
`timescale 1ns/1ps
module ems_enc_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // master side
  input wire logic line_drive_enable,
  input wire logic shift_clk,
  // reply setup
  input wire logic [31:0] reply_bits,
  input wire logic [5:0] reply_len,
  input wire logic [9:0] reply_delay,
  // data line
  output logic data_line
);
  logic drv_q, clk_q;
  logic [1:0] ph;
  logic [9:0] cnt;
  logic [5:0] idx;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_line <= 1'b1;
      ph <= 2'd0;
      drv_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      drv_q <= line_drive_enable;
      clk_q <= shift_clk;
      if (line_drive_enable) begin
        data_line <= 1'b1;
        ph <= 2'd0;
      end else if (ph == 2'd0 && drv_q) begin
        ph <= 2'd1;
        cnt <= 10'd0;
      end else if (ph == 2'd1) begin
        cnt <= cnt + 10'd1;
        if (cnt == reply_delay) begin
          data_line <= reply_bits[0];
          idx <= 6'd1;
          ph <= 2'd2;
        end
      end else if (ph == 2'd2 && clk_q && !shift_clk) begin
        data_line <= (idx < reply_len) ? reply_bits[idx[4:0]] : 1'b1;
        idx <= idx + 6'd1;
        if (idx >= reply_len) begin
          ph <= 2'd3;
        end
      end
    end
  end
endmodule : ems_enc_model

// ===== tb/ems_encoder_master_sequencer_tb.sv
/*
  Self-checking bench for the encoder master sequencer.
  Assumes the encoder model on the data line and the bound checker.
*/
`timescale 1ns/1ps
module ems_encoder_master_sequencer_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd, pat = 32'h0;
  logic pready, pslverr, line, sclk, clk_oe, drive, er, sq = 1'b0;
  logic [5:0] rlen = 6'd0;
  logic [9:0] dly = 10'd0;
  logic [31:0] exp_q[$];
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD};
  int fail_count = 0, samples_checked = 0, ntx, nrx;
  int tx_r = 0, rx_r = 0, run = 0, gap = 0, hi = 0;
  always #2.5 core_clk = ~core_clk;
  localparam logic [7:0] CT = ems_pkg::OFS_CTRL, ST = ems_pkg::OFS_STATUS, RX = ems_pkg::OFS_RXDATA;
  localparam logic [7:0] CD = ems_pkg::OFS_CLKDIV, OM = ems_pkg::OFS_OUTMASK;
  ems_encoder_master_sequencer ems_encoder_master_sequencer_i (.core_clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .encoder_edge_input(line), .shift_clk_out(sclk), .shift_clk_oe(clk_oe),
    .output_crossbar_six(drive));
  ems_enc_model ems_enc_model_i (.core_clk, .arst_n,
    .line_drive_enable(drive), .shift_clk(sclk), .reply_bits(pat), .reply_len(rlen),
    .reply_delay(dly), .data_line(line));
  always @(posedge core_clk) begin
    sq <= sclk;
    run <= run + 1;
    hi <= sclk ? hi + 1 : hi;
    if (sclk && !sq) begin
      if (drive) tx_r <= tx_r + 1;
      else rx_r <= rx_r + 1;
      gap <= run;
      run <= 1;
      hi <= 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic [3:0] m, input int t, input int r, input int p,
                      input logic [31:0] b, input int w);
    logic [31:0] v;
    int n;
    n = r + p;
    pat <= b & 32'hFFFF_FFFE;
    rlen <= 6'(r);
    dly <= 10'(w);
    apb(1, ems_pkg::OFS_LEN, {8'h00, 8'(p), 8'(r), 8'(t)});
    apb(1, ems_pkg::OFS_CMD, {28'h0, m});
    chk({31'h0, drive | sclk}, 32'h0);
    ntx = tx_r + t;
    nrx = rx_r + n;
    apb(1, CT, 32'hA);
    apb(1, CT, 32'hB);
    v = (b & 32'hFFFF_FFFE) | ~((32'h1 << r) - 32'h1);
    v = (v & ((32'h1 << n) - 32'h1)) << (32 - n);
    exp_q.push_back(v);
  endtask : xfer
  task automatic finish();
    for (int k = 0; k < 3000; k++) begin
      apb(0, ST, 0);
      if (rd[0] === 1'b0) break;
    end
    chk({28'h0, rd[4:3], rd[0], 1'b0}, 32'h4);
    chk(32'(tx_r), 32'(ntx));
    chk(32'(rx_r), 32'(nrx));
    apb(1, ST, 32'h8);
    apb(1, CT, 32'hA);
  endtask : finish
  task automatic pop();
    apb(0, RX, 0);
    chk(rd, exp_q.pop_front());
  endtask : pop
  task automatic t_reset();
    chk({29'h0, drive, sclk, clk_oe}, 32'h0);
    apb(0, OM, 0);
    chk(rd, 32'h3C);
    pstrb <= 4'h3;
    apb(1, CD, 32'hFFFF_0007);
    pstrb <= 4'hF;
    apb(0, CD, 0);
    chk(rd, {ems_pkg::MATCH2_RST, 16'h0007});
    apb(0, 8'h40, 0);
    chk({31'h0, er}, 32'h1);
    apb(1, CT, 32'hA);
    apb(1, OM, 32'h34);
    repeat (2) @(posedge core_clk);
    chk({31'h0, clk_oe}, 32'h0);
    apb(1, OM, 32'h3C);
    repeat (2) @(posedge core_clk);
    chk({31'h0, clk_oe}, 32'h1);
  endtask : t_reset
  task automatic t_modes();
    apb(1, CD, {16'd11, 16'd5});
    for (int i = 0; i < 8; i++) begin
      xfer(codes[i], 10, 12 + i, 4, 32'h5A3C_96E1 ^ (i << 5), 20);
      finish();
      apb(0, ST, 0);
      chk(32'(rd[11:8]), 32'(i + 1));
    end
    chk(32'(gap * 100 + hi), 32'd1205);
    xfer(codes[8], 10, 20, 0, 32'hC3A5_0F0E, 20);
    for (int k = 0; k < 2000 && rx_r < nrx; k++) @(posedge core_clk);
    apb(0, ST, 0);
    chk({rd[11:8], rd[0]}, 5'h11);
    for (int i = 0; i < 8; i++) pop();
    finish();
    pop();
    apb(0, RX, 0);
    chk(rd, 32'h0);
  endtask : t_modes
  task automatic t_refuse();
    xfer(4'h4, 10, 8, 0, 32'h0, 5);
    void'(exp_q.pop_back());
    apb(0, ST, 0);
    chk({27'h0, rd[4:0]}, 32'h10);
    apb(1, ST, 32'h10);
    apb(1, ems_pkg::OFS_CMD, 32'h1);
    apb(1, CT, 32'hB);
    repeat (40) @(posedge core_clk);
    chk(32'(tx_r), 32'(ntx - 10));
    apb(1, CT, 32'hA);
  endtask : t_refuse
  task automatic t_busy();
    xfer(4'h3, 6, 9, 0, 32'h0000_0156, 300);
    apb(1, CT, 32'hA);
    apb(1, CT, 32'hB);
    finish();
    apb(0, ST, 0);
    chk(32'(rd[4]), 32'h0);
    pop();
  endtask : t_busy
  task automatic t_slow();
    apb(1, CD, {16'd79, 16'd40});
    xfer(4'h2, 3, 5, 3, 32'h0000_0016, 300);
    finish();
    chk(32'(gap * 100 + hi), 32'd8040);
    pop();
  endtask : t_slow
  task automatic t_seqrst();
    xfer(4'hD, 4, 8, 0, 32'h0000_00A4, 600);
    for (int k = 0; k < 2000 && tx_r < ntx; k++) @(posedge core_clk);
    repeat (400) @(posedge core_clk);
    apb(1, CT, 32'hE);
    void'(exp_q.pop_back());
    repeat (400) @(posedge core_clk);
    apb(0, ST, 0);
    chk({rd[11:8], rd[2:0], 32'(rx_r - nrx + 8)}, 32'h0);
    xfer(4'h7, 4, 8, 0, 32'h0000_00B2, 10);
    finish();
    pop();
  endtask : t_seqrst
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    $display("reset end");
    t_modes();
    $display("modes end");
    t_refuse();
    $display("refuse end");
    t_busy();
    $display("busy end");
    t_slow();
    $display("slow end");
    t_seqrst();
    $display("seqreset end");
    results();
  end
  initial begin
    #500_000;
    fail_count++;
    results();
  end
endmodule : ems_encoder_master_sequencer_tb

// ===== tb/ems_seq_props.sv
/*
  Port checker for the encoder master sequencer.
  Assumes binding to the sequencer top; one clock.
*/
`timescale 1ns/1ps
module ems_seq_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic encoder_edge_input,
  input wire logic shift_clk_out,
  input wire logic output_crossbar_six
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == ems_pkg::OFS_CTRL;
  sequence quiet_wait;
    $fell(output_crossbar_six) ##1 (encoder_edge_input && !output_crossbar_six)[*4];
  endsequence
  pready_wait_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  start_lat_a: assert property ($rose(output_crossbar_six) |->
    $past(ctrl_wr, 3) || $past(ctrl_wr, 4)) else $error("drive without start");
  drive_clock_a: assert property ($rose(output_crossbar_six) |-> ##[0:2] shift_clk_out)
    else $error("no clock while sending");
  drive_fall_a: assert property ($fell(output_crossbar_six) |-> !shift_clk_out)
    else $error("drive fell with clock high");
  wait_quiet_a: assert property (quiet_wait |-> !shift_clk_out)
    else $error("clock before start bit");
  clk_high_a: assert property ($rose(shift_clk_out) |=> shift_clk_out)
    else $error("clock glitch");
  cover property (pslverr);
  cover property ($rose(output_crossbar_six));
  cover property (quiet_wait);
endmodule : ems_seq_props

bind ems_encoder_master_sequencer ems_seq_props ems_seq_props_i (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .encoder_edge_input, .shift_clk_out, .output_crossbar_six);
